// File: hw/dsc_refresh_timer.sv
/*
  auto-refresh interval counter.
  assumes the sequencer only enables it while the memory is in use.
*/
`timescale 1ns/1ps
`default_nettype none

module dsc_refresh_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // control
  input  wire logic        enable,
  input  wire logic [15:0] interval,
  // one-cycle refresh due pulse
  output logic             tick
);

  logic [15:0] cnt_r;
  logic        hit;

  assign hit = (interval != 16'h0000) && (cnt_r >= interval - 16'h0001); // R9 R10

  // counter reloads on each tick; held clear while disabled or interval zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt_r <= 16'h0000;
    else if (!enable || interval == 16'h0000 || hit) // R10
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_r + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      tick <= 1'b0;
    else
      tick <= enable && hit; // R9
  end

endmodule

`default_nettype wire

// File: hw/dsc_top.sv
/*
  display sdram setup control: avalon-mm register slave, geometry and
  timing decode, power-up initialization, auto refresh and power saving.
  assumes read addresses and bandwidth alarms come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"

module dsc_top #(
  parameter int POWERUP_CYCLES = `DSC_POWERUP_CYC,
  parameter int INIT_REFRESHES = `DSC_INIT_REFRESHES
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // avalon-mm slave
  input  wire logic [9:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [3:0]         byteenable,
  input  wire logic [31:0]        writedata,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  // display path events
  input  wire logic               rd_valid,
  input  wire logic [27:0]        rd_addr,
  input  wire logic               bw_short,
  // sdram pins
  output logic                    sdram_cke,
  output logic                    sdram_cs_n,
  output logic                    sdram_ras_n,
  output logic                    sdram_cas_n,
  output logic                    sdram_we_n,
  output logic [12:0]             sdram_addr,
  output logic [1:0]              sdram_ba,
  // decoded configuration
  output logic                    cfg_four_banks,
  output dsc_pkg::dsc_nib_t       cfg_row_bits,
  output dsc_pkg::dsc_nib_t       cfg_col_bits,
  output logic [1:0]              cfg_cas_clocks,
  output dsc_pkg::dsc_clocks_t    cfg_t_rcd,
  output dsc_pkg::dsc_clocks_t    cfg_t_ras,
  output dsc_pkg::dsc_clocks_t    cfg_t_wr,
  // status
  output logic                    mem_ready,
  output logic                    mem_in_save
);
  import dsc_pkg::*;

  logic [7:0]  geometry_r;
  logic [7:0]  mode_r;
  logic [15:0] refresh_r;
  logic [7:0]  timing1_r;
  logic [7:0]  timing2_r;
  logic [7:0]  timing3_r;
  logic [7:0]  timing4_r;
  logic        override_r;
  logic        sleep_r;
  logic        warn_r;
  logic        init_done_r;
  logic        init_start_r;
  logic        save_self_r;
  dsc_state_e  state_r;
  dsc_cmd_t    cmd_r;
  logic [3:0]  ref_left_r;
  logic [31:0] rd_nxt;
  logic [7:0]  idx;
  logic        aligned;
  logic        req_take;
  logic        wr_fire;
  logic [7:0]  wbyte;
  logic        tmr_load;
  logic [15:0] tmr_value;
  logic        tmr_expired;
  logic        ref_tick;
  logic        ref_pending_r;
  logic [3:0]  row_bits;
  logic [3:0]  col_bits;
  logic [4:0]  total_bits;
  logic [28:0] capacity;
  logic        warn_event;
  logic [2:0]  cas_code;
  logic [4:0]  t_mrd;
  logic [4:0]  t_rfc;
  logic [4:0]  t_xsr;
  logic [4:0]  t_rp;

  assign idx      = address[9:2];
  assign aligned  = (address[1:0] == 2'b00);
  assign req_take = (read || write) && waitrequest;
  assign wr_fire  = write && !waitrequest && aligned && byteenable[0];
  assign wbyte    = writedata[7:0];

  // one wait state on every access, so read data can come from a flop
  always_ff @(posedge clk)
  begin
    if (!rstn)
      waitrequest <= 1'b1;
    else
      waitrequest <= !req_take;
  end

  // read mux; unmapped and unaligned reads answer zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (aligned)
    begin
      case (idx)
        `DSC_IDX_GEOMETRY: rd_nxt[7:0] = geometry_r;
        `DSC_IDX_MODE:     rd_nxt[7:0] = mode_r;
        `DSC_IDX_REF_LO:   rd_nxt[7:0] = refresh_r[7:0]; // R8
        `DSC_IDX_REF_HI:   rd_nxt[7:0] = refresh_r[15:8]; // R8
        `DSC_IDX_CONTROL:  rd_nxt[7:0] = {4'h0, warn_r, override_r, sleep_r, init_done_r}; // R11 R15
        `DSC_IDX_TIMING1:  rd_nxt[7:0] = timing1_r;
        `DSC_IDX_TIMING2:  rd_nxt[7:0] = timing2_r;
        `DSC_IDX_TIMING3:  rd_nxt[7:0] = timing3_r;
        `DSC_IDX_TIMING4:  rd_nxt[7:0] = timing4_r;
        default:           rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      readdata <= 32'h0000_0000;
    else if (req_take && read)
      readdata <= rd_nxt;
  end

  // geometry and timing registers; geometry must match the fitted part
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      geometry_r <= `DSC_RST_GEOMETRY;
      timing1_r  <= `DSC_RST_TIMING1;
      timing2_r  <= `DSC_RST_TIMING2;
      timing3_r  <= `DSC_RST_TIMING3;
      timing4_r  <= `DSC_RST_TIMING4;
    end
    else if (wr_fire)
    begin
      case (idx)
        `DSC_IDX_GEOMETRY: geometry_r <= wbyte;
        `DSC_IDX_TIMING1:  timing1_r  <= {4'h0, wbyte[3:0]};
        `DSC_IDX_TIMING2:  timing2_r  <= wbyte;
        `DSC_IDX_TIMING3:  timing3_r  <= wbyte;
        `DSC_IDX_TIMING4:  timing4_r  <= wbyte;
        default:           timing1_r  <= timing1_r;
      endcase
    end
  end

  // mode byte freezes once the memory has been initialized
  always_ff @(posedge clk)
  begin
    if (!rstn)
      mode_r <= `DSC_RST_MODE;
    else if (wr_fire && idx == `DSC_IDX_MODE && !init_done_r) // R7
      mode_r <= wbyte;
  end

  // refresh interval, low byte at the lower index
  always_ff @(posedge clk)
  begin
    if (!rstn)
      refresh_r <= `DSC_RST_REFRESH; // R8
    else if (wr_fire && idx == `DSC_IDX_REF_LO)
      refresh_r[7:0] <= wbyte; // R8
    else if (wr_fire && idx == `DSC_IDX_REF_HI)
      refresh_r[15:8] <= wbyte; // R8
  end

  // control bits; the sleep level is compared against the sequencer state
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      override_r <= 1'b0;
      sleep_r    <= 1'b0;
    end
    else if (wr_fire && idx == `DSC_IDX_CONTROL)
    begin
      override_r <= wbyte[`DSC_CTL_OVERRIDE];
      sleep_r    <= wbyte[`DSC_CTL_SLEEP];
    end
  end

  // launch only on a 1 while still uninitialized; a 0 does nothing
  always_ff @(posedge clk)
  begin
    if (!rstn)
      init_start_r <= 1'b0;
    else
      init_start_r <= wr_fire && idx == `DSC_IDX_CONTROL && wbyte[`DSC_CTL_INIT] &&
                      !init_done_r && state_r == dsc_st_uninit; // R15 R16
  end

  // capacity in bytes of a x16 part from the decoded geometry
  always_comb
  begin
    case (geometry_r[`DSC_GEO_ROW_LSB +: 2]) // R3
      2'b00:   row_bits = 4'd11;
      2'b01:   row_bits = 4'd12;
      default: row_bits = 4'd13;
    endcase
    if (!geometry_r[`DSC_GEO_BANK])
      col_bits = 4'd8; // R2
    else
    begin
      case (geometry_r[`DSC_GEO_COL_LSB +: 3]) // R4
        3'b000:  col_bits = 4'd8;
        3'b001:  col_bits = 4'd9;
        3'b010:  col_bits = 4'd10;
        3'b011:  col_bits = 4'd11;
        default: col_bits = 4'd12;
      endcase
    end
    total_bits = 5'(row_bits) + 5'(col_bits) + (geometry_r[`DSC_GEO_BANK] ? 5'd3 : 5'd2); // R2
  end

  assign capacity   = 29'h1 << total_bits;
  assign warn_event = (rd_valid && ({1'b0, rd_addr} + `DSC_NEAR_BYTES >= capacity)) || bw_short; // R11

  // sticky warning; a new event beats a clearing write in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
      warn_r <= 1'b0;
    else if (warn_event)
      warn_r <= 1'b1; // R11
    else if (wr_fire && idx == `DSC_IDX_CONTROL && !wbyte[`DSC_CTL_WARN])
      warn_r <= 1'b0; // R12
  end

  // timing in clocks: built-in values unless the override is on
  assign t_mrd = 5'(override_r ? timing1_r[3:0] : 4'(`DSC_RST_TIMING1)) + 5'd1; // R13 R18
  assign t_rfc = 5'(override_r ? timing2_r[7:4] : 4'(`DSC_RST_TIMING2 >> 4)) + 5'd1; // R13 R18
  assign t_xsr = 5'(override_r ? timing2_r[3:0] : 4'(`DSC_RST_TIMING2)) + 5'd1; // R13 R18
  assign t_rp  = 5'(override_r ? timing3_r[7:4] : 4'(`DSC_RST_TIMING3 >> 4)) + 5'd1; // R13 R18
  assign cas_code = (mode_r[2:0] == `DSC_CAS_TWO) ? `DSC_CAS_TWO : `DSC_CAS_THREE; // R5

  // decoded configuration for the display data path
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cfg_four_banks <= 1'b1;
      cfg_row_bits   <= 4'd12;
      cfg_col_bits   <= 4'd8;
      cfg_cas_clocks <= 2'd3;
      cfg_t_rcd      <= 5'd3;
      cfg_t_ras      <= 5'd7;
      cfg_t_wr       <= 5'd1;
    end
    else
    begin
      cfg_four_banks <= geometry_r[`DSC_GEO_BANK]; // R2
      cfg_row_bits   <= row_bits; // R3
      cfg_col_bits   <= col_bits; // R4
      cfg_cas_clocks <= cas_code[1:0]; // R5
      cfg_t_rcd      <= 5'(override_r ? timing4_r[7:4] : 4'(`DSC_RST_TIMING4 >> 4)) + 5'd1; // R13 R18
      cfg_t_ras      <= 5'(override_r ? timing4_r[3:0] : 4'(`DSC_RST_TIMING4)) + 5'd1; // R13 R18
      cfg_t_wr       <= 5'(override_r ? timing3_r[3:0] : 4'(`DSC_RST_TIMING3)) + 5'd1; // R13 R18
    end
  end

  dsc_wait_timer #(
    .W       (16)
  ) u_wait (
    .clk     (clk),
    .rstn    (rstn),
    .load    (tmr_load),
    .value   (tmr_value),
    .expired (tmr_expired)
  );

  dsc_refresh_timer u_refresh (
    .clk      (clk),
    .rstn     (rstn),
    .enable   (init_done_r && state_r != dsc_st_save),
    .interval (refresh_r),
    .tick     (ref_tick)
  );

  // a due refresh is held until the sequencer can issue it
  always_ff @(posedge clk)
  begin
    if (!rstn)
      ref_pending_r <= 1'b0;
    else if (ref_tick)
      ref_pending_r <= 1'b1; // R9
    else if (state_r == dsc_st_ready && tmr_load && cmd_r == `DSC_CMD_NOP && !sleep_r)
      ref_pending_r <= 1'b0;
  end

  // timer loads happen together with command issue or a cke rise; value is spacing minus one
  always_comb
  begin
    tmr_load  = 1'b0;
    tmr_value = 16'h0000;
    case (state_r)
      dsc_st_uninit:    begin tmr_load = init_start_r; tmr_value = 16'(POWERUP_CYCLES - 1); end
      dsc_st_init_pre:  begin tmr_load = 1'b1; tmr_value = 16'(t_rp - 5'd1); end
      dsc_st_init_ref:  begin tmr_load = 1'b1; tmr_value = 16'(t_rfc - 5'd1); end
      dsc_st_init_mrs:  begin tmr_load = 1'b1; tmr_value = 16'(t_mrd - 5'd1); end
      dsc_st_ready:     begin tmr_load = ref_pending_r && !sleep_r; tmr_value = 16'(t_rfc - 5'd1); end
      dsc_st_save:      begin tmr_load = !sleep_r; tmr_value = save_self_r ? 16'(t_xsr - 5'd1) : 16'h0000; end
      default:          begin tmr_load = 1'b0; tmr_value = 16'h0000; end
    endcase
  end

  // sequencer: initialization, refresh and power saving
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r     <= dsc_st_uninit;
      cmd_r       <= `DSC_CMD_NOP;
      sdram_cke   <= 1'b0;
      sdram_addr  <= 13'h0000;
      ref_left_r  <= 4'h0;
      init_done_r <= 1'b0;
      save_self_r <= 1'b0;
    end
    else
    begin
      cmd_r      <= `DSC_CMD_NOP;
      sdram_addr <= 13'h0000;
      case (state_r)
        dsc_st_uninit:
          if (init_start_r) // R15
          begin
            sdram_cke <= 1'b1;
            state_r   <= dsc_st_powerup;
          end
        dsc_st_powerup:
          if (tmr_expired)
            state_r <= dsc_st_init_pre;
        dsc_st_init_pre:
        begin
          cmd_r          <= `DSC_CMD_PRECHARGE; // R19
          sdram_addr[10] <= 1'b1;
          ref_left_r     <= 4'(INIT_REFRESHES);
          state_r        <= dsc_st_init_trp;
        end
        dsc_st_init_trp:
          if (tmr_expired)
            state_r <= dsc_st_init_ref;
        dsc_st_init_ref:
        begin
          cmd_r      <= `DSC_CMD_REFRESH; // R19
          ref_left_r <= ref_left_r - 4'h1;
          state_r    <= dsc_st_init_trfc;
        end
        dsc_st_init_trfc:
          if (tmr_expired)
            state_r <= (ref_left_r == 4'h0) ? dsc_st_init_mrs : dsc_st_init_ref;
        dsc_st_init_mrs:
        begin
          cmd_r           <= `DSC_CMD_LOAD_MODE; // R19
          sdram_addr[6:4] <= cas_code; // R5
          state_r         <= dsc_st_init_tmrd;
        end
        dsc_st_init_tmrd:
          if (tmr_expired)
          begin
            init_done_r <= 1'b1; // R15 R19
            state_r     <= dsc_st_ready;
          end
        dsc_st_ready:
          if (sleep_r) // R14
          begin
            save_self_r <= geometry_r[`DSC_GEO_SAVE_METHOD];
            sdram_cke   <= 1'b0;
            cmd_r       <= geometry_r[`DSC_GEO_SAVE_METHOD] ? `DSC_CMD_REFRESH : `DSC_CMD_NOP; // R1
            state_r     <= dsc_st_save;
          end
          else if (ref_pending_r)
          begin
            cmd_r   <= `DSC_CMD_REFRESH; // R9
            state_r <= dsc_st_ref_trfc;
          end
        dsc_st_ref_trfc:
          if (tmr_expired)
            state_r <= dsc_st_ready;
        dsc_st_save:
          if (!sleep_r) // R14
          begin
            sdram_cke <= 1'b1;
            state_r   <= dsc_st_exit_wait;
          end
        dsc_st_exit_wait:
          if (tmr_expired)
            state_r <= dsc_st_ready;
        default:
          state_r <= dsc_st_uninit;
      endcase
    end
  end

  // command pins and status straight from flops
  assign sdram_cs_n  = cmd_r[3];
  assign sdram_ras_n = cmd_r[2];
  assign sdram_cas_n = cmd_r[1];
  assign sdram_we_n  = cmd_r[0];
  assign sdram_ba    = 2'b00;
  assign mem_ready   = init_done_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      mem_in_save <= 1'b0;
    else
      mem_in_save <= (state_r == dsc_st_save);
  end

endmodule

`default_nettype wire

// File: hw/dsc_wait_timer.sv
/*
  down counter spacing sdram commands.
  assumes the loader gives the wanted spacing minus one.
*/
`timescale 1ns/1ps
`default_nettype none

module dsc_wait_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // load side
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // expiry
  output logic              expired
);

  logic [W-1:0] cnt_r;

  // a load overrides any count still running
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (load)
      cnt_r <= value;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - W'(1);
  end

  assign expired = (cnt_r == '0);

endmodule

`default_nettype wire

// File: include/dsc_defines.svh
/*
  constants of the display sdram setup control block: register indices,
  field positions, reset values, sdram command codes and timing counts.
  assumes a 10 mhz clock and a x16 sdram device behind the block.

// Summary of operation
// R1 - power saving enters self refresh when the method bit is 1, power-down when 0
// R2 - bank setting: 1 (reset) four banks, 0 two banks with 256 columns only
// R3 - row setting: 00b 2k rows, 01b 4k rows (reset), 1xb 8k rows
// R4 - column setting: 256, 512, 1024, 2048, 4096 columns for 000b..011b, 1xxb
// R5 - cas latency 010b is two clocks, 011b (reset) three; others reserved
// R6 - software should program the mode byte to 03h, cas latency three
// R7 - mode byte locks once initialization is done; later writes ignored
// R8 - refresh interval is 16 bits over two bytes, low byte first, reset zero
// R9 - one auto-refresh each time the counter reaches the interval, then reload
// R10 - a zero refresh interval stops all automatic refresh
// R11 - sticky warning on reads within 512 bytes of the top or bandwidth shortfall
// R12 - writing 0 to the warning bit clears the flag
// R13 - timing parameter registers apply only while override enable is 1
// R14 - sleep bit rising enters power saving, falling leaves it
// R15 - writing 1 while 0 starts initialization; reads 1 once memory is ready
// R16 - once set, writing 0 to the init bit is ignored and starts nothing
// R17 - software must program the geometry to match the fitted memory
// R18 - each four-bit timing field means field value plus one clocks
// R19 - init precharges all, auto-refreshes, loads mode register, then reports ready
*/
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// register indices; byte address is four times the index
`define DSC_IDX_GEOMETRY    8'he0
`define DSC_IDX_MODE        8'he1
`define DSC_IDX_REF_LO      8'he2
`define DSC_IDX_REF_HI      8'he3
`define DSC_IDX_CONTROL     8'he4
`define DSC_IDX_TIMING1     8'hf0
`define DSC_IDX_TIMING2     8'hf1
`define DSC_IDX_TIMING3     8'hf2
`define DSC_IDX_TIMING4     8'hf3

// field positions
`define DSC_GEO_SAVE_METHOD 7
`define DSC_GEO_BANK        5
`define DSC_GEO_ROW_LSB     3
`define DSC_GEO_COL_LSB     0
`define DSC_CTL_WARN        3
`define DSC_CTL_OVERRIDE    2
`define DSC_CTL_SLEEP       1
`define DSC_CTL_INIT        0

// reset values
`define DSC_RST_GEOMETRY    8'h28
`define DSC_RST_MODE        8'h03
`define DSC_RST_REFRESH     16'h0000
`define DSC_RST_TIMING1     8'h02
`define DSC_RST_TIMING2     8'h87
`define DSC_RST_TIMING3     8'h20
`define DSC_RST_TIMING4     8'h26

// cas latency codes
`define DSC_CAS_TWO         3'h2
`define DSC_CAS_THREE       3'h3

// sdram commands as {cs_n, ras_n, cas_n, we_n}
`define DSC_CMD_NOP         4'h7
`define DSC_CMD_PRECHARGE   4'h2
`define DSC_CMD_REFRESH     4'h1
`define DSC_CMD_LOAD_MODE   4'h0

// timing
`define DSC_CLK_PERIOD_NS   100
`define DSC_POWERUP_NS      100000
`define DSC_POWERUP_CYC     ((`DSC_POWERUP_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS)
`define DSC_NEAR_BYTES      29'h200
`define DSC_INIT_REFRESHES  2

`endif

// File: include/dsc_pkg.sv
/*
  types shared by the display sdram setup control files.
  assumes nothing of its surroundings.
*/
package dsc_pkg;

  // control sequencer states
  typedef enum logic [3:0] {
    dsc_st_uninit,
    dsc_st_powerup,
    dsc_st_init_pre,
    dsc_st_init_trp,
    dsc_st_init_ref,
    dsc_st_init_trfc,
    dsc_st_init_mrs,
    dsc_st_init_tmrd,
    dsc_st_ready,
    dsc_st_ref_trfc,
    dsc_st_save,
    dsc_st_exit_wait
  } dsc_state_e;

  typedef logic [3:0] dsc_cmd_t;
  typedef logic [4:0] dsc_clocks_t;
  typedef logic [3:0] dsc_nib_t;

endpackage

// File: tb/dsc_monitor.sv
/*
  assertions on the register handshake, sdram commands and config decode.
  assumes a bind into dsc_top, one clock clk and sync reset rstn.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"

module dsc_monitor (
  // clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // register bus
  input wire logic              read,
  input wire logic              write,
  input wire logic              waitrequest,
  // sdram pins
  input wire logic              sdram_cke,
  input wire logic              sdram_cs_n,
  input wire logic              sdram_ras_n,
  input wire logic              sdram_cas_n,
  input wire logic              sdram_we_n,
  input wire logic [12:0]       sdram_addr,
  // config and status
  input wire logic              cfg_four_banks,
  input wire dsc_pkg::dsc_nib_t cfg_row_bits,
  input wire dsc_pkg::dsc_nib_t cfg_col_bits,
  input wire logic [1:0]        cfg_cas_clocks,
  input wire logic              mem_ready,
  input wire logic              mem_in_save
);
  import dsc_pkg::*;
  wire [3:0] cmd = {sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // handshake: exactly one wait state, low for one cycle
  wait_one_a: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("waitrequest not low after one wait state");
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  // init commands carry their documented fields; ready holds, cke stays low in save
  pre_all_a: assert property (cmd == `DSC_CMD_PRECHARGE |-> sdram_addr[10])
    else $error("precharge without all-bank bit");
  mrs_cas_a: assert property (cmd == `DSC_CMD_LOAD_MODE |->
    sdram_addr[6:4] == ((cfg_cas_clocks == 2'd2) ? 3'h2 : 3'h3))
    else $error("mode load cas code wrong");
  mrs_ready_a: assert property (cmd == `DSC_CMD_LOAD_MODE && !mem_ready |-> ##[1:17] mem_ready)
    else $error("ready not reported after mode load");
  ready_hold_a: assert property (mem_ready |=> mem_ready)
    else $error("ready dropped after init");
  save_cke_a: assert property (mem_in_save && !$rose(sdram_cke) |-> !sdram_cke)
    else $error("clock enable high in power save");
  // geometry decode
  two_bank_a: assert property (!cfg_four_banks |-> cfg_col_bits == 4'd8)
    else $error("two banks without 256 columns");
  row_range_a: assert property (cfg_row_bits inside {4'd11, 4'd12, 4'd13})
    else $error("row count out of range");

  cover property ($rose(mem_ready));
  cover property ($rose(mem_in_save));
  cover property (cmd == `DSC_CMD_REFRESH && mem_ready && sdram_cke);
endmodule
`default_nettype wire

// File: tb/dsc_sdram_model.sv
/*
  behavioural sdram seen from its command pins; counts and orders commands.
  assumes commands are sampled on the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"

module dsc_sdram_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // sdram pins
  input  wire logic        cke,
  input  wire logic [3:0]  cmd,
  input  wire logic [12:0] addr,
  // observed counts
  output logic [15:0]      ref_cnt,
  output logic [3:0]       self_cnt,
  output logic [2:0]       mrs_cas,
  output logic             seq_ok
);
  logic pre_seen;

  // refresh with cke high is auto refresh, with cke low self refresh entry
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ref_cnt  <= 16'h0;
      self_cnt <= 4'h0;
      mrs_cas  <= 3'h0;
      seq_ok   <= 1'b0;
      pre_seen <= 1'b0;
    end
    else
    begin
      if (cmd == `DSC_CMD_PRECHARGE && addr[10])
        pre_seen <= 1'b1;
      if (cmd == `DSC_CMD_REFRESH && cke)
        ref_cnt <= ref_cnt + 16'h1;
      if (cmd == `DSC_CMD_REFRESH && !cke)
        self_cnt <= self_cnt + 4'h1;
      // mode load only counts as ordered after precharge and refreshes
      if (cmd == `DSC_CMD_LOAD_MODE)
      begin
        mrs_cas <= addr[6:4];
        seq_ok  <= pre_seen && ref_cnt >= 16'd2;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_display_sdram_setup_control.sv
/*
  self-checking bench: register map, decode, warning, init, refresh, sleep.
  assumes the sdram model and the monitor; powerup shortened to 5 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defines.svh"

module tb_display_sdram_setup_control;
  import dsc_pkg::*;
  logic        clk = 0, rstn = 0, read = 0, write = 0, rd_valid = 0, bw_short = 0;
  logic [9:0]  address = 0;
  logic [3:0]  byteenable = 0;
  logic [31:0] writedata = 0, readdata, rq;
  logic [27:0] rd_addr = 0;
  logic        waitrequest, sdram_cke, sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n;
  logic        cfg_four_banks, mem_ready, mem_in_save, seq_ok;
  logic [12:0] sdram_addr;
  logic [1:0]  sdram_ba, cfg_cas_clocks;
  dsc_nib_t    cfg_row_bits, cfg_col_bits;
  dsc_clocks_t cfg_t_rcd, cfg_t_ras, cfg_t_wr;
  logic [15:0] ref_cnt;
  logic [3:0]  self_cnt;
  logic [2:0]  mrs_cas;
  logic [7:0]  g, t, u;
  logic [7:0]  ix[10] = '{8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'h40};
  logic [7:0]  rv[10] = '{8'h28, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02, 8'h87, 8'h20, 8'h26, 8'h00};
  int          bad_count = 0, check_count = 0, n0, n1;
  integer      seed = 32'h9f5e4aa1;

  dsc_top #(.POWERUP_CYCLES(5)) DUT (.*);
  dsc_sdram_model u_mem (.clk, .rstn, .cke(sdram_cke), .cmd({sdram_cs_n, sdram_ras_n, sdram_cas_n,
    sdram_we_n}), .addr(sdram_addr), .ref_cnt, .self_cnt, .mrs_cas, .seq_ok);

  // free-running clock, 100 ns period
  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    read       <= !w;
    write      <= w;
    address    <= {idx, 2'b00};
    writedata  <= {24'h0, d};
    byteenable <= 4'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0);
    rq = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    chk(n, 32'd2);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h0);
    chk(rq, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  function automatic logic [3:0] row_of(input logic [7:0] v);
    return v[4] ? 4'd13 : (v[3] ? 4'd12 : 4'd11);
  endfunction

  // two banks force 256 columns whatever the column code
  function automatic logic [3:0] col_of(input logic [7:0] v);
    return !v[5] ? 4'd8 : (v[2] ? 4'd12 : 4'd8 + {2'b0, v[1:0]});
  endfunction

  // hang guard, far beyond the roughly 1200 cycles the sequence needs
  initial
  begin
    #3000000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rdc(ix[i], {24'h0, rv[i]});
    chk({cfg_four_banks, cfg_row_bits, cfg_col_bits, cfg_cas_clocks}, {1'b1, 4'd12, 4'd8, 2'd3});
    chk({cfg_t_rcd, cfg_t_ras, cfg_t_wr}, {5'd3, 5'd7, 5'd1});
    // corner then random geometry codes, bit 6 kept 0
    for (int i = 0; i < 8; i++)
    begin
      g = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : 8'($random(seed)) & 8'hbf;
      wr(8'he0, g);
      cyc(2);
      chk({cfg_four_banks, cfg_row_bits, cfg_col_bits}, {g[5], row_of(g), col_of(g)});
      rdc(8'he0, {24'h0, g});
    end
    wr(8'he1, 8'h02);
    cyc(2);
    chk(cfg_cas_clocks, 2'd2);
    wr(8'he1, 8'h03);
    wr(8'he0, 8'h28);
    // 8 MiB fitted: warn at 512 below top, not at 513, and on bandwidth
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      rd_valid <= (i < 2);
      bw_short <= (i == 2);
      rd_addr  <= 28'h800000 - ((i == 1) ? 28'd513 : 28'd512);
      @(posedge clk);
      rd_valid <= 1'b0;
      bw_short <= 1'b0;
      rdc(8'he4, (i == 1) ? 32'h0 : 32'h8);
      wr(8'he4, 8'h00);
      rdc(8'he4, 32'h0);
    end
    wr(8'he4, 8'h01);
    for (int k = 0; k < 300 && mem_ready !== 1'b1; k++)
      @(posedge clk);
    rdc(8'he4, 32'h1);
    chk({seq_ok, mrs_cas}, {1'b1, 3'h3});
    wr(8'he1, 8'h02);
    rdc(8'he1, 32'h3);
    wr(8'he4, 8'h00);
    rdc(8'he4, 32'h1);
    // zero interval stays silent, then a random short interval
    n0 = ref_cnt;
    cyc(300);
    chk(ref_cnt - n0, 32'h0);
    u = 8'($random(seed));
    wr(8'he3, u);
    rdc(8'he3, {24'h0, u});
    wr(8'he3, 8'h00);
    t = 8'd16 + (8'($random(seed)) & 8'h0f);
    wr(8'he2, t);
    n0 = ref_cnt;
    cyc(600);
    n1 = ref_cnt - n0;
    chk(n1 >= 600 / t - 1 && n1 <= 600 / t + 1, 1'b1);
    t = 8'($random(seed));
    wr(8'hf3, t);
    wr(8'hf2, u);
    cyc(2);
    chk({cfg_t_rcd, cfg_t_ras, cfg_t_wr}, {5'd3, 5'd7, 5'd1});
    wr(8'he4, 8'h04);
    cyc(2);
    chk({cfg_t_rcd, cfg_t_ras, cfg_t_wr}, {5'd1 + t[7:4], 5'd1 + t[3:0], 5'd1 + u[3:0]});
    wr(8'he4, 8'h00);
    // power down first, self refresh second
    for (int i = 0; i < 2; i++)
    begin
      wr(8'he0, (i == 1) ? 8'ha8 : 8'h28);
      n0 = self_cnt;
      wr(8'he4, 8'h02);
      cyc(14); // a refresh in flight delays entry
      chk({mem_in_save, sdram_cke, 4'(self_cnt - n0)}, {2'b10, 4'(i)});
      wr(8'he4, 8'h00);
      cyc(30);
      chk({mem_in_save, sdram_cke, mem_ready, sdram_ba}, 5'b01100);
    end
    tally_and_finish();
  end
endmodule

bind dsc_top dsc_monitor u_mon (.*);
`default_nettype wire
